//--- hdl/dlt_consts.svh
// Constants of the die link target and interrupt mirror.
// Assumes inclusion by bare name from the design file and the bench files.
`ifndef DLT_CONSTS_SVH
`define DLT_CONSTS_SVH

// Bases the initiator strips before sending an offset
`define DLT_BASE_BLOCKING    16'h0200
`define DLT_BASE_NONBLOCKING 16'h0300

// Register offsets inside the 256-byte window
`define DLT_OFS_MIRROR_LO 8'h00
`define DLT_OFS_MIRROR_HI 8'h01
`define DLT_OFS_VECTOR    8'h02
`define DLT_OFS_VSTAT     8'h05

// Command nibble: bit 2 selects word, bits 1:0 the kind
`define DLT_CMD_WIDE_BIT 2
`define DLT_KIND_NONE    2'h0
`define DLT_KIND_RD      2'h1
`define DLT_KIND_WR      2'h2
`define DLT_KIND_NBW     2'h3
`define DLT_CMD_WAKE     4'h8

// Answer nibbles
`define DLT_NIB_WAIT  4'h0
`define DLT_STAT_DONE 4'h9
`define DLT_STAT_ERR  4'hA

// Mirror bit positions
`define DLT_MIR_VS    0
`define DLT_MIR_CHAN0 1
`define DLT_MIR_OVF   5
`define DLT_MIR_ERR   6
`define DLT_MIR_TX    7
`define DLT_MIR_RX    8
`define DLT_MIR_CONV  9
`define DLT_MIR_DRVOT 10
`define DLT_MIR_HIOT  11
`define DLT_MIR_LOOT  12
`define DLT_MIR_HOT   13

// Voltage flag positions, status register order
`define DLT_VS_LB   0
`define DLT_VS_LV   1
`define DLT_VS_HV   2
`define DLT_VS_HT   3
`define DLT_VS_VROV 4

// Reset values
`define DLT_MIRROR_RST 16'h0000
`define DLT_NIB_RST    4'h0

`endif

//--- hdl/dlt_pkg.sv
// Types of the die link target and interrupt mirror.
// Assumes dlt_consts.svh is on the include path.
`default_nettype none
package dlt_pkg;
   // Power mode supplied by the analog die mode control
   typedef enum logic [1:0] {
      DLT_NORMAL = 2'b00,
      DLT_STOP   = 2'b01,
      DLT_SLEEP  = 2'b10
   } dlt_mode_t;

   // Link side transaction states
   typedef enum logic [2:0] {
      DLT_IDLE = 3'b000,
      DLT_ADDR = 3'b001,
      DLT_DATA = 3'b010,
      DLT_TURN = 3'b011,
      DLT_WAIT = 3'b100,
      DLT_STAT = 3'b101,
      DLT_RDAT = 3'b110
   } dlt_lst_t;

   // All link-domain state
   typedef struct packed {
      dlt_lst_t    st;
      logic [3:0]  cmd;
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [1:0]  cnt;
      logic [3:0]  qCmd;
      logic [7:0]  qAddr;
      logic [15:0] qData;
      logic        reqTgl;
      logic        ackS1;
      logic        ackS2;
      logic [15:0] rdata;
      logic [3:0]  nibOut;
      logic        nibOe;
      logic        wakeTgl;
   } dlt_link_t;

   // All core-domain state
   typedef struct packed {
      logic        reqS1;
      logic        reqS2;
      logic        ackTgl;
      logic        rdPend;
      logic [15:0] rdata;
      logic        err;
      logic        wakeS1;
      logic        wakeS2;
      logic        wakeSeen;
      logic        wakeLat;
      logic [4:0]  voltPrev;
      logic [4:0]  voltLat;
      logic [3:0]  statPrev;
      logic [3:0]  statLat;
      logic        perWr;
      logic        perRd;
      logic [7:0]  perAddr;
      logic [15:0] perWdata;
      logic        perWide;
      logic        wakePulse;
      logic        sleep;
      logic        irq;
   } dlt_core_t;
endpackage
`default_nettype wire

//--- hdl/dlt_irq_mirror.sv
// Die link target with interrupt source mirror and vector register.
// Assumes the initiator clocks the link and holds the clock running
// through a transaction; peripherals answer reads in the strobe cycle.
`include "dlt_consts.svh"
`default_nettype none

// Functional notes
// - Write: command, offset, data, then delivered
// - Read: command, offset, then data returned
// - Full 256-byte offset space is decoded
// - Blocking read/write and posted write
// - Four-bit two-way data path, link clock
// - No training; first clock edge starts
// - End answer carries done or error
// - Sleep disables target, data pins low
// - Stop: wake command raises interrupt line
// - Clock input only, nibble two-way, irq out
// - Line high until source acknowledged
// - Source interrupts only in normal mode
// - Voltage source ORs five flags
// - Mirror read-only, reading clears nothing
// - Fixed mirror bit order, top two zero
// - Offsets relative to blocking/posted bases
// - Vector is priority number times two
// - Vector read acknowledges nothing
// - Vector bits 5:0, zero when idle
// - Priority low voltage first, overvoltage last
// - Status source rearms after condition clears
module dlt_irq_mirror (
   // Core clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire dlt_pkg::dlt_mode_t powerMode,
   // Die link pins
   input  wire logic             die_link_clock,
   input  wire logic [3:0]       die_link_nibble_in,
   output logic      [3:0]       die_link_nibble_out,
   output logic                  die_link_nibble_oe,
   output logic                  die_link_irq_out,
   // Interrupt sources
   input  wire logic [4:0]       voltCond,
   input  wire logic [3:0]       statCond,
   input  wire logic [3:0]       statAck,
   input  wire logic [3:0]       timerChan,
   input  wire logic             timerOvf,
   input  wire logic             serialErr,
   input  wire logic             serialTx,
   input  wire logic             serialRx,
   input  wire logic             convDone,
   // Peripheral access port
   output logic                  perWrStb,
   output logic                  perRdStb,
   output logic      [7:0]       perAddr,
   output logic      [15:0]      perWdata,
   output logic                  perWide,
   input  wire logic [15:0]      perRdata,
   // Wake event towards mode control
   output logic                  wakeEvent
);

   // Link-domain state and its next value
   dlt_pkg::dlt_link_t lnk_r;
   dlt_pkg::dlt_link_t lnk_nxt;
   // Core-domain state and its next value
   dlt_pkg::dlt_core_t cor_r;
   dlt_pkg::dlt_core_t cor_nxt;

   // Live interrupt view
   logic [15:0] mirror;      // Source mirror contents
   logic [17:0] prioPend;    // Pending, index 0 is highest
   logic [5:0]  vector;      // Priority code times two

   // Request decode in the core domain
   logic        reqNew;      // Unserved request seen
   logic [1:0]  reqKind;     // Kind of that request
   logic        reqWide;     // Word access
   logic        vstatRead;   // Status read acknowledges voltage
   logic        linkBusy;    // Earlier request still open

   // Pending sources gathered into the mirror
   always_comb begin
      mirror = `DLT_MIRROR_RST;
      mirror[`DLT_MIR_VS] = |cor_r.voltLat;
      mirror[`DLT_MIR_CHAN0 +: 4] = timerChan;
      mirror[`DLT_MIR_OVF]   = timerOvf;
      mirror[`DLT_MIR_ERR]   = serialErr;
      mirror[`DLT_MIR_TX]    = serialTx;
      mirror[`DLT_MIR_RX]    = serialRx;
      mirror[`DLT_MIR_CONV]  = convDone;
      mirror[`DLT_MIR_DRVOT] = cor_r.statLat[0];
      mirror[`DLT_MIR_HIOT]  = cor_r.statLat[1];
      mirror[`DLT_MIR_LOOT]  = cor_r.statLat[2];
      mirror[`DLT_MIR_HOT]   = cor_r.statLat[3];
   end

   // Sources in priority order, then the winning code
   always_comb begin
      prioPend = {cor_r.voltLat[`DLT_VS_VROV],
                  cor_r.voltLat[`DLT_VS_HV],
                  cor_r.statLat[3], cor_r.statLat[2],
                  cor_r.statLat[1], cor_r.statLat[0],
                  convDone, serialRx, serialTx, serialErr,
                  timerOvf, timerChan[3], timerChan[2],
                  timerChan[1], timerChan[0],
                  cor_r.voltLat[`DLT_VS_LB],
                  cor_r.voltLat[`DLT_VS_HT],
                  cor_r.voltLat[`DLT_VS_LV]};
      vector = 6'h00;
      for (int i = 17; i >= 0; i--) begin
         if (prioPend[i]) begin
            vector = 6'((i + 1) * 2);
         end
      end
   end

   // Link-domain transaction sequencer
   // starts on first edge
   always_comb begin
      lnk_nxt = lnk_r;
      // Acknowledge toggle, two-stage crossing
      lnk_nxt.ackS1 = cor_r.ackTgl;
      lnk_nxt.ackS2 = lnk_r.ackS1;
      linkBusy = lnk_r.reqTgl != lnk_r.ackS2;
      case (lnk_r.st)
         dlt_pkg::DLT_IDLE: begin
            lnk_nxt.nibOe = 1'b0;
            if (die_link_nibble_in == `DLT_CMD_WAKE) begin
               lnk_nxt.wakeTgl = ~lnk_r.wakeTgl;
            end else if (die_link_nibble_in[1:0] !=
                         `DLT_KIND_NONE) begin
               lnk_nxt.cmd = die_link_nibble_in;
               lnk_nxt.cnt = 2'h1;
               lnk_nxt.st  = dlt_pkg::DLT_ADDR;
            end
         end
         dlt_pkg::DLT_ADDR: begin
            lnk_nxt.addr = {lnk_r.addr[3:0], die_link_nibble_in};
            lnk_nxt.cnt  = lnk_r.cnt - 2'h1;
            if (lnk_r.cnt == 2'h0) begin
               if (lnk_r.cmd[1:0] == `DLT_KIND_RD) begin
                  lnk_nxt.st = dlt_pkg::DLT_TURN;
               end else begin
                  lnk_nxt.cnt = lnk_r.cmd[`DLT_CMD_WIDE_BIT] ?
                                2'h3 : 2'h1;
                  lnk_nxt.st  = dlt_pkg::DLT_DATA;
               end
            end
         end
         dlt_pkg::DLT_DATA: begin
            lnk_nxt.wdata = {lnk_r.wdata[11:0], die_link_nibble_in};
            lnk_nxt.cnt   = lnk_r.cnt - 2'h1;
            if (lnk_r.cnt == 2'h0) begin
               lnk_nxt.st = dlt_pkg::DLT_TURN;
            end
         end
         dlt_pkg::DLT_TURN: begin
            lnk_nxt.nibOe = 1'b1;
            if (linkBusy) begin
               // Posted write still open: refuse
               lnk_nxt.nibOut = `DLT_STAT_ERR;
               lnk_nxt.cmd    = `DLT_NIB_RST;
               lnk_nxt.st     = dlt_pkg::DLT_STAT;
            end else begin
               lnk_nxt.qCmd   = lnk_r.cmd;
               lnk_nxt.qAddr  = lnk_r.addr;
               lnk_nxt.qData  = lnk_r.wdata;
               lnk_nxt.reqTgl = ~lnk_r.reqTgl;
               if (lnk_r.cmd[1:0] == `DLT_KIND_NBW) begin
                  lnk_nxt.nibOut = `DLT_STAT_DONE;
                  lnk_nxt.st     = dlt_pkg::DLT_STAT;
               end else begin
                  lnk_nxt.nibOut = `DLT_NIB_WAIT;
                  lnk_nxt.st     = dlt_pkg::DLT_WAIT;
               end
            end
         end
         dlt_pkg::DLT_WAIT: begin
            // Blocking: hold wait until core answers
            if (!linkBusy) begin
               lnk_nxt.nibOut = cor_r.err ? `DLT_STAT_ERR :
                                `DLT_STAT_DONE;
               lnk_nxt.rdata  = lnk_r.cmd[`DLT_CMD_WIDE_BIT] ?
                                cor_r.rdata :
                                {cor_r.rdata[7:0], 8'h00};
               if (cor_r.err) begin
                  lnk_nxt.cmd = `DLT_NIB_RST;
               end
               lnk_nxt.st = dlt_pkg::DLT_STAT;
            end
         end
         dlt_pkg::DLT_STAT: begin
            if (lnk_r.cmd[1:0] == `DLT_KIND_RD) begin
               lnk_nxt.nibOut = lnk_r.rdata[15:12];
               lnk_nxt.rdata  = {lnk_r.rdata[11:0], 4'h0};
               lnk_nxt.cnt    = lnk_r.cmd[`DLT_CMD_WIDE_BIT] ?
                                2'h3 : 2'h1;
               lnk_nxt.st     = dlt_pkg::DLT_RDAT;
            end else begin
               lnk_nxt.nibOe = 1'b0;
               lnk_nxt.st    = dlt_pkg::DLT_IDLE;
            end
         end
         dlt_pkg::DLT_RDAT: begin
            if (lnk_r.cnt == 2'h0) begin
               lnk_nxt.nibOe = 1'b0;
               lnk_nxt.st    = dlt_pkg::DLT_IDLE;
            end else begin
               lnk_nxt.nibOut = lnk_r.rdata[15:12];
               lnk_nxt.rdata  = {lnk_r.rdata[11:0], 4'h0};
               lnk_nxt.cnt    = lnk_r.cnt - 2'h1;
            end
         end
         default: begin
            lnk_nxt.nibOe = 1'b0;
            lnk_nxt.st    = dlt_pkg::DLT_IDLE;
         end
      endcase
   end

   // Link state register; reset only loads constants
   always_ff @(posedge die_link_clock or posedge sys_rst) begin
      if (sys_rst) begin
         lnk_r <= '0;
      end else begin
         lnk_r <= lnk_nxt;
      end
   end

   // Core-side request view; request words are stable once seen
   always_comb begin
      reqNew  = (cor_r.reqS2 != cor_r.ackTgl) && !cor_r.rdPend;
      reqKind = lnk_r.qCmd[1:0];
      reqWide = lnk_r.qCmd[`DLT_CMD_WIDE_BIT];
      vstatRead = cor_r.perRd && (cor_r.perAddr == `DLT_OFS_VSTAT);
   end

   // Core-domain register decode, sources and wake
   always_comb begin
      cor_nxt = cor_r;
      cor_nxt.perWr     = 1'b0;
      cor_nxt.perRd     = 1'b0;
      cor_nxt.wakePulse = 1'b0;
      cor_nxt.sleep     = powerMode == dlt_pkg::DLT_SLEEP;
      // Request toggle, two-stage crossing
      cor_nxt.reqS1 = lnk_r.reqTgl;
      cor_nxt.reqS2 = cor_r.reqS1;
      // Peripheral read completes in its strobe cycle
      if (cor_r.rdPend) begin
         cor_nxt.rdPend = 1'b0;
         cor_nxt.rdata  = perRdata;
         cor_nxt.err    = 1'b0;
         cor_nxt.ackTgl = cor_r.reqS2;
      end
      if (reqNew) begin
         if (lnk_r.qAddr > `DLT_OFS_VECTOR) begin // Port moves with strobe
            cor_nxt.perAddr  = lnk_r.qAddr;
            cor_nxt.perWdata = lnk_r.qData;
            cor_nxt.perWide  = reqWide;
         end
         cor_nxt.err      = 1'b0;
         if (reqKind == `DLT_KIND_RD) begin
            if (lnk_r.qAddr == `DLT_OFS_MIRROR_LO) begin
               cor_nxt.rdata  = reqWide ? mirror :
                                {8'h00, mirror[7:0]};
               cor_nxt.ackTgl = cor_r.reqS2;
            end else if (lnk_r.qAddr == `DLT_OFS_MIRROR_HI) begin
               cor_nxt.rdata  = {8'h00, mirror[15:8]};
               cor_nxt.ackTgl = cor_r.reqS2;
            end else if (lnk_r.qAddr == `DLT_OFS_VECTOR) begin
               cor_nxt.rdata  = {10'h000, vector};
               cor_nxt.ackTgl = cor_r.reqS2;
            end else begin
               cor_nxt.perRd  = 1'b1;
               cor_nxt.rdPend = 1'b1;
            end
         end else begin
            // Writes to the read-only registers are errors
            if (lnk_r.qAddr == `DLT_OFS_MIRROR_LO ||
                lnk_r.qAddr == `DLT_OFS_MIRROR_HI ||
                lnk_r.qAddr == `DLT_OFS_VECTOR) begin
               cor_nxt.err = 1'b1;
            end else begin
               cor_nxt.perWr = 1'b1;
            end
            cor_nxt.ackTgl = cor_r.reqS2;
         end
      end
      cor_nxt.voltPrev = voltCond;
      cor_nxt.statPrev = statCond;
      // held until acknowledged
      // A new edge in the clearing cycle wins over the clear
      cor_nxt.voltLat = (cor_r.voltLat & {5{~vstatRead}}) |
                        (voltCond & ~cor_r.voltPrev);
      cor_nxt.statLat = (cor_r.statLat & ~statAck) |
                        (statCond & ~cor_r.statPrev);
      // Wake toggle, two-stage crossing
      cor_nxt.wakeS1   = lnk_r.wakeTgl;
      cor_nxt.wakeS2   = cor_r.wakeS1;
      cor_nxt.wakeSeen = cor_r.wakeS2;
      if (powerMode != dlt_pkg::DLT_STOP) begin
         cor_nxt.wakeLat = 1'b0;
      end else if (cor_r.wakeS2 != cor_r.wakeSeen) begin
         cor_nxt.wakeLat   = 1'b1;
         cor_nxt.wakePulse = 1'b1;
      end
      case (powerMode)
         dlt_pkg::DLT_NORMAL: cor_nxt.irq = |mirror;
         dlt_pkg::DLT_STOP:   cor_nxt.irq = cor_r.wakeLat;
         default:             cor_nxt.irq = 1'b0;
      endcase
   end

   // Core state register; reset only loads constants
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cor_r <= '0;
      end else begin
         cor_r <= cor_nxt;
      end
   end

   // Pin drive; sleep overrides the link side from the next core clock edge
   always_comb begin
      die_link_nibble_out = cor_r.sleep ? `DLT_NIB_RST :
                            lnk_r.nibOut;
      die_link_nibble_oe  = cor_r.sleep | lnk_r.nibOe;
      die_link_irq_out    = cor_r.irq;
   end

   // Peripheral port and wake pulse, all registered
   always_comb begin
      perWrStb  = cor_r.perWr;
      perRdStb  = cor_r.perRd;
      perAddr   = cor_r.perAddr;
      perWdata  = cor_r.perWdata;
      perWide   = cor_r.perWide;
      wakeEvent = cor_r.wakePulse;
   end

endmodule
`default_nettype wire

//--- dv/dlt_irq_props.sv
// Checker of the die link target and interrupt mirror ports.
// Assumes it is bound to dlt_irq_mirror and sees its ports only.
`include "dlt_consts.svh"
`default_nettype none
module dlt_irq_props (
   // Clocks and reset
   input wire logic               core_clk,
   input wire logic               sys_rst,
   input wire logic               die_link_clock,
   // Mode and direct sources
   input wire dlt_pkg::dlt_mode_t powerMode,
   input wire logic [3:0]         timerChan,
   input wire logic               timerOvf,
   input wire logic               serialErr,
   input wire logic               serialTx,
   input wire logic               serialRx,
   input wire logic               convDone,
   // Outputs watched
   input wire logic [3:0]         die_link_nibble_out,
   input wire logic               die_link_nibble_oe,
   input wire logic               die_link_irq_out,
   input wire logic               perWrStb,
   input wire logic               perRdStb,
   input wire logic [7:0]         perAddr,
   input wire logic               perWide,
   input wire logic               wakeEvent
);
   // Any source mirrored without a latch
   logic evAny;
   assign evAny = |{timerChan, timerOvf, serialErr, serialTx, serialRx,
                    convDone};

   a_sleep_pins: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (powerMode == dlt_pkg::DLT_SLEEP) [*3] |->
      die_link_nibble_oe && die_link_nibble_out == 4'h0)
      else $error("Pins not held low in sleep");
   a_src_irq: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (powerMode == dlt_pkg::DLT_NORMAL && evAny) [*2] |-> die_link_irq_out)
      else $error("Pending source without interrupt line");
   a_wake_mode: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      wakeEvent |-> powerMode == dlt_pkg::DLT_STOP ##1 !wakeEvent)
      else $error("Wake pulse outside stop or too long");
   a_wake_irq: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      wakeEvent |-> ##[0:4] die_link_irq_out)
      else $error("Wake did not raise the line");
   a_wr_pulse: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      perWrStb |=> !perWrStb && !perRdStb)
      else $error("Write strobe longer than one cycle");
   a_rd_pulse: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      perRdStb |=> !perRdStb && !perWrStb)
      else $error("Read strobe longer than one cycle");
   a_ro_nowr: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      perWrStb |-> perAddr > `DLT_OFS_VECTOR)
      else $error("Write reached a read-only offset");
   a_addr_hold: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $changed(perAddr) |-> perWrStb || perRdStb)
      else $error("Peripheral address moved without request");
   a_oe_answer: assert property (
      @(posedge die_link_clock) disable iff (sys_rst)
      $rose(die_link_nibble_oe) |-> die_link_nibble_out inside
      {`DLT_NIB_WAIT, `DLT_STAT_DONE, `DLT_STAT_ERR})
      else $error("Answer began with a bad nibble");

   // Main scenarios reached
   c_wake: cover property (@(posedge core_clk) wakeEvent);
   c_word_rd: cover property (@(posedge core_clk) perRdStb && perWide);
   c_byte_wr: cover property (@(posedge core_clk) perWrStb && !perWide);
   c_sleep: cover property (@(posedge core_clk)
      powerMode == dlt_pkg::DLT_SLEEP && die_link_nibble_oe);
endmodule

bind dlt_irq_mirror dlt_irq_props dlt_irq_props_i (.*);
`default_nettype wire

//--- dv/dlt_init_model.sv
// Initiator model of the die link: clock, frames, wake command.
// Assumes the target samples the pins on rising link clock edges.
`include "dlt_consts.svh"
`default_nettype none
module dlt_init_model (
   // Link clock, stands low between frames
   output logic            linkClk,
   // Resolved pin level fed to the target
   output logic [3:0]      pinLvl,
   // Target drive of the pins
   input  wire logic [3:0] tgtOut,
   input  wire logic       tgtOe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       drv;  // Model drives the pins
   logic [3:0] val;  // Nibble it drives

   assign pinLvl = drv ? val : (tgtOe ? tgtOut : 4'h0);

   // Idle link at time zero
   initial begin
      linkClk = 1'b0;
      drv = 1'b0;
      val = 4'h0;
   end

   // One 30 ns link cycle, pins change after the fall
   task automatic tick(input logic [3:0] v, input logic d);
      drv = d;
      val = v;
      #15 linkClk = 1'b1;
      #15 linkClk = 1'b0;
   endtask

   // Whole frame: command, two offset nibbles and nd data nibbles sent, nr nibbles read back
   task automatic xfer(input logic [3:0] cmd, input logic [7:0] a,
                       input logic [15:0] wd, input int nd,
                       input int nr, output logic [3:0] st,
                       output logic [15:0] rd);
      #1.3;
      tick(cmd, 1'b1);
      tick(a[7:4], 1'b1);
      tick(a[3:0], 1'b1);
      for (int i = nd - 1; i >= 0; i--) tick(wd[i*4 +: 4], 1'b1);
      // Turnaround, then wait out the bounded blocking answer
      tick(4'h0, 1'b0);
      for (int i = 0; i < 24 && pinLvl === 4'h0; i++) tick(4'h0, 1'b0);
      st = pinLvl;
      rd = 16'h0000;
      for (int i = 0; i < nr && st === `DLT_STAT_DONE; i++) begin
         tick(4'h0, 1'b0);
         rd = {rd[11:0], pinLvl};
      end
      tick(4'h0, 1'b0);
   endtask

   // Wake command on an idle edge
   task automatic wake();
      #1.3;
      tick(`DLT_CMD_WAKE, 1'b1);
      tick(4'h0, 1'b0);
   endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the die link target and interrupt mirror.
// Assumes the initiator model and the checker are compiled first.
`include "dlt_consts.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic               core_clk, sys_rst; // Clock, reset
   dlt_pkg::dlt_mode_t powerMode; // Power mode
   logic               linkClk, nibOe, irq; // Link clock, drive, line
   logic [3:0]         pinLvl, nibOut; // Pin level, target drive
   logic [4:0]         voltCond, ev; // Volt levels; done rx tx err ovf
   logic [3:0]         statCond, statAck, timerChan; // Status, timers
   logic               perWrStb, perRdStb, perWide, wakeEvent; // Strobes
   logic [7:0]         perAddr, wrA; // Offsets
   logic [15:0]        perWdata, perRdata, wrD; // Data
   logic [4:0]         vPrev = 5'h00, vLat = 5'h00; // Model voltage
   logic [3:0]         sPrev = 4'h0, sLat = 4'h0; // Model status
   logic [31:0]        seed = 32'h3FC7D3A5; // Random state
   int                 failures = 0, tests_run = 0;
   int                 wrN = 0, wkN = 0; // Writes, wakes seen

   dlt_irq_mirror dlt_irq_mirror_i (
      .core_clk, .sys_rst, .powerMode,
      .die_link_clock(linkClk), .die_link_nibble_in(pinLvl),
      .die_link_nibble_out(nibOut), .die_link_nibble_oe(nibOe),
      .die_link_irq_out(irq), .voltCond, .statCond, .statAck,
      .timerChan, .timerOvf(ev[0]), .serialErr(ev[1]),
      .serialTx(ev[2]), .serialRx(ev[3]), .convDone(ev[4]),
      .perWrStb, .perRdStb, .perAddr, .perWdata, .perWide,
      .perRdata, .wakeEvent);
   dlt_init_model dlt_init_model_i (.linkClk, .pinLvl,
      .tgtOut(nibOut), .tgtOe(nibOe));

   // Core clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Peripheral answers from its offset, ready before the strobe edge
   always @(negedge core_clk) perRdata <= {perAddr ^ 8'h3C, ~perAddr};

   // Peripheral writes and wake pulses
   always @(posedge core_clk) begin
      if (perWrStb === 1'b1) begin
         wrN <= wrN + 1;
         wrA <= perAddr;
         wrD <= perWdata;
      end
      if (wakeEvent === 1'b1) wkN <= wkN + 1;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected mirror word
   function automatic logic [15:0] expMir();
      return {2'b00, sLat, ev, timerChan, |vLat};
   endfunction

   // Expected vector: lowest index wins, code twice index plus two
   function automatic logic [15:0] expVec();
      logic [17:0] p;
      p = {vLat[4], vLat[2], sLat, ev, timerChan, vLat[0], vLat[3],
           vLat[1]};
      expVec = 16'h0000;
      for (int i = 17; i >= 0; i--) if (p[i]) expVec = 16'(2 * i + 2);
      return expVec;
   endfunction

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got %h want %h", $time, g, e);
      end
   endtask

   // New source levels; model latches follow rising conditions
   task automatic src(input logic [31:0] r);
      @(negedge core_clk);
      {statCond, voltCond, ev, timerChan} = r[17:0];
      vLat = vLat | (voltCond & ~vPrev);
      sLat = sLat | (statCond & ~sPrev);
      vPrev = voltCond;
      sPrev = statCond;
      repeat (4) @(negedge core_clk);
   endtask

   // Blocking read that must finish with the done status
   task automatic rd(input logic [7:0] a, input logic w,
                     input logic [15:0] ed);
      logic [3:0]  st;
      logic [15:0] d;
      dlt_init_model_i.xfer({1'b0, w, `DLT_KIND_RD}, a, 16'h0000, 0,
                            w ? 4 : 2, st, d);
      chk({12'h000, st}, {12'h000, `DLT_STAT_DONE});
      chk(d, ed);
   endtask

   // Write of kind k; delivery expected only on done status
   task automatic wr(input logic [1:0] k, input logic [7:0] a,
                     input logic w, input logic [15:0] wd,
                     input logic [3:0] es);
      logic [3:0]  st;
      logic [15:0] d;
      logic [15:0] mk;
      int          n0;
      n0 = wrN;
      mk = w ? 16'hFFFF : 16'h00FF;
      dlt_init_model_i.xfer({1'b0, w, k}, a, wd & mk, w ? 4 : 2, 0, st, d);
      chk({12'h000, st}, {12'h000, es});
      for (int i = 0; i < 40 && wrN == n0; i++) @(negedge core_clk);
      chk(16'(wrN - n0), {15'h0000, es == `DLT_STAT_DONE});
      if (wrN != n0) chk({wrA, 8'h00}, {a, 8'h00});
      if (wrN != n0) chk(wrD & mk, wd & mk);
   endtask

   // Status acknowledge pulse
   task automatic ack(input logic [3:0] m);
      @(negedge core_clk);
      statAck = m;
      @(negedge core_clk);
      statAck = 4'h0;
      sLat = sLat & ~m;
   endtask

   task automatic wrap_up();
      $display("Checks made %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Run takes about 25 us; cut a hang after that
   initial begin
      #300000;
      failures++;
      wrap_up();
   end

   // Main sequence
   initial begin
      logic [15:0] m;
      logic [31:0] r;
      int          n0;
      sys_rst = 1'b1;
      powerMode = dlt_pkg::DLT_NORMAL;
      {voltCond, statCond, statAck, timerChan, ev} = '0;
      repeat (10) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge core_clk);
      rd(`DLT_OFS_MIRROR_LO, 1'b1, 16'h0000);
      rd(`DLT_OFS_VECTOR, 1'b0, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      // Sparse random sources, then every view of them
      for (int n = 0; n < 12; n++) begin
         r = 32'hFFFFFFFF;
         repeat (3) begin
            repeat (9) seed = lfsr(seed);
            r = r & seed;
         end
         src(r);
         m = expMir();
         rd(`DLT_OFS_MIRROR_LO, 1'b1, m);
         rd(`DLT_OFS_MIRROR_LO, 1'b0, {8'h00, m[7:0]});
         rd(`DLT_OFS_MIRROR_HI, 1'b0, {8'h00, m[15:8]});
         rd(`DLT_OFS_VECTOR, 1'b0, expVec());
         rd(`DLT_OFS_MIRROR_LO, 1'b1, m);
         chk({15'h0000, irq}, {15'h0000, |m});
         if (seed[5]) begin
            rd(`DLT_OFS_VSTAT, 1'b0, 16'h00FA);
            vLat = 5'h00;
         end
         if (seed[6]) ack(seed[10:7]);
      end
      // Blocking, posted and refused writes
      wr(`DLT_KIND_WR, 8'h40, 1'b1, seed[15:0], `DLT_STAT_DONE);
      wr(`DLT_KIND_NBW, 8'hC3, 1'b0, seed[31:16], `DLT_STAT_DONE);
      wr(`DLT_KIND_WR, 8'h00, 1'b0, 16'h0011, `DLT_STAT_ERR);
      rd(8'hFF, 1'b1, 16'hC300);
      // Stop: line carries wake only
      @(negedge core_clk);
      powerMode = dlt_pkg::DLT_STOP;
      src(32'h00000002);
      chk({15'h0000, irq}, 16'h0000);
      n0 = wkN;
      dlt_init_model_i.wake();
      for (int i = 0; i < 20 && wkN == n0; i++) @(negedge core_clk);
      chk(16'(wkN - n0), 16'h0001);
      chk({15'h0000, irq}, 16'h0001);
      // Sleep: pins low, no interrupt
      powerMode = dlt_pkg::DLT_SLEEP;
      repeat (4) @(negedge core_clk);
      chk({10'h000, nibOe, nibOut, irq}, 16'h0020);
      powerMode = dlt_pkg::DLT_NORMAL;
      repeat (4) @(negedge core_clk);
      rd(`DLT_OFS_MIRROR_LO, 1'b1, expMir());
      wrap_up();
   end
endmodule
`default_nettype wire
